// [verilog/cds_data_space.sv]
// core data-space decoder: banks, bit space, stack and core special registers
`default_nettype none
module cds_data_space (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// decoder request
	input wire logic reqValid,
	input wire cds_pkg::cds_mode_type reqMode,
	input wire logic reqWrite,
	input wire logic reqIsBit,
	input wire logic [7:0] reqAddr,
	input wire logic [2:0] reqRegNum,
	input wire logic reqPtrSel,
	input wire logic [7:0] reqWdata,
	input wire logic reqBitVal,
	input wire logic [15:0] reqRetAddr,
	// decoder answer
	output logic reqReady,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspBit,
	// core registers seen by the datapath
	output logic [7:0] primaryValue,
	output logic [7:0] secondValue,
	output logic [7:0] statusWord,
	output logic [7:0] stackPtr
);
	import cds_pkg::*;

	cds_core_if coreIf ();

	cds_scratch_ram u_ram (
		.mclk(mclk),
		.bus(coreIf)
	);

	cds_stack_ptr u_sp (
		.mclk(mclk),
		.reset_n(reset_n),
		.bus(coreIf)
	);

	logic [7:0] primary_q;
	logic [7:0] second_q;
	logic [7:0] status_q;
	logic reqReady_q;
	logic rspValid_q;
	logic [7:0] rspData_q;
	logic rspBit_q;
	logic [7:0] pcHi_q;
	logic [7:0] pcHi_d;
	cds_state_type st_q;
	cds_state_type st_d;

	logic [1:0] bank;
	logic accept;
	logic bitOp;
	logic byteWrite;
	logic pushOp;
	logic popOp;
	logic callOp;
	logic [7:0] opAddr;
	logic opSpecial;
	logic [2:0] bitIdx;
	logic [7:0] curByte;
	logic [7:0] newByte;
	logic curBit;
	logic specialWrite;
	logic [7:0] topValue;

	function automatic logic specialHit(input logic [7:0] a);
		return (a == PRIMARY_REG_ADDR) || (a == SECOND_REG_ADDR) ||
			(a == STATUS_WORD_ADDR) || (a == STACK_TOP_ADDR);
	endfunction

	// any address with no register behind it answers all ones
	function automatic logic [7:0] specialRead(input logic [7:0] a, input logic [7:0] primV,
		input logic [7:0] secV, input logic [7:0] statV, input logic [7:0] topV);
		logic [7:0] v;
		v = UNIMPL_READ;
		if (a == PRIMARY_REG_ADDR) begin
			v = primV;
		end else if (a == SECOND_REG_ADDR) begin
			v = secV;
		end else if (a == STATUS_WORD_ADDR) begin
			v = statV;
		end else if (a == STACK_TOP_ADDR) begin
			v = topV;
		end
		return v;
	endfunction

	assign topValue = coreIf.stkTop;
	assign bank = status_q[BANK_SEL_LSB +: 2];
	assign accept = reqValid && reqReady_q;
	assign pushOp = accept && (reqMode == MODE_PUSH);
	assign popOp = accept && (reqMode == MODE_POP);
	assign callOp = accept && (reqMode == MODE_CALL);
	assign bitOp = reqIsBit && (reqMode == MODE_DIRECT);
	assign byteWrite = accept && reqWrite &&
		((reqMode == MODE_DIRECT) || (reqMode == MODE_INDIRECT) || (reqMode == MODE_WREG));

	// pointer registers of the active bank
	assign coreIf.ptrAddr = {3'b000, bank, 2'b00, reqPtrSel};

	always_comb begin
		opAddr = reqAddr;
		opSpecial = 1'b0;
		bitIdx = reqAddr[2:0];
		case (reqMode)
			MODE_DIRECT: begin
				// only a direct operand may reach the special space
				opSpecial = reqAddr[7];
				if (reqIsBit) begin
					if (reqAddr[7]) begin
						opAddr = {reqAddr[7:3], 3'b000};
					end else begin
						opAddr = {BIT_RAM_HI, reqAddr[6:3]};
					end
				end
			end
			MODE_INDIRECT: begin
				opAddr = coreIf.ptrData;
			end
			MODE_WREG: begin
				opAddr = {3'b000, bank, reqRegNum};
			end
			MODE_POP: begin
				opAddr = topValue;
			end
			default: begin
				opAddr = topValue + ONE_STEP;
			end
		endcase
	end

	assign coreIf.rdAddr = opAddr;

	always_comb begin
		if (opSpecial) begin
			curByte = specialRead(opAddr, primary_q, second_q, status_q, topValue);
		end else begin
			curByte = coreIf.rdData;
		end
		curBit = curByte[bitIdx];
		newByte = reqWdata;
		if (bitOp) begin
			// read-modify-write keeps the other seven bits
			newByte = curByte;
			newByte[bitIdx] = reqBitVal;
		end
	end

	// a write to an unimplemented special address is dropped
	assign specialWrite = byteWrite && opSpecial && specialHit(opAddr);

	always_comb begin
		coreIf.wrEn = 1'b0;
		coreIf.wrAddr = opAddr;
		coreIf.wrData = newByte;
		if (st_q == ST_PUSH_HI) begin
			coreIf.wrEn = 1'b1;
			coreIf.wrAddr = topValue + ONE_STEP;
			coreIf.wrData = pcHi_q;
		end else if (pushOp || callOp) begin
			coreIf.wrEn = 1'b1;
			coreIf.wrData = reqWdata;
			if (callOp) begin
				coreIf.wrData = reqRetAddr[7:0];
			end
		end else if (byteWrite && !opSpecial) begin
			coreIf.wrEn = 1'b1;
		end
	end

	assign coreIf.stkInc = pushOp || callOp || (st_q == ST_PUSH_HI);
	assign coreIf.stkDec = popOp;
	assign coreIf.stkLoad = specialWrite && (opAddr == STACK_TOP_ADDR);
	assign coreIf.stkLoadVal = newByte;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			primary_q <= PRIMARY_RESET;
		end else if (specialWrite && (opAddr == PRIMARY_REG_ADDR)) begin
			primary_q <= newByte;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			second_q <= SECOND_RESET;
		end else if (specialWrite && (opAddr == SECOND_REG_ADDR)) begin
			second_q <= newByte;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= STATUS_RESET;
		end else if (specialWrite && (opAddr == STATUS_WORD_ADDR)) begin
			status_q <= newByte;
		end
	end

	// a call takes two edges: low byte first, then high byte
	always_comb begin
		st_d = ST_IDLE;
		pcHi_d = pcHi_q;
		case (st_q)
			ST_IDLE: begin
				if (callOp) begin
					st_d = ST_PUSH_HI;
					pcHi_d = reqRetAddr[15:8];
				end
			end
			ST_PUSH_HI: begin
				st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE;
			pcHi_q <= 8'h00;
			reqReady_q <= 1'b1;
		end else begin
			st_q <= st_d;
			pcHi_q <= pcHi_d;
			reqReady_q <= (st_d == ST_IDLE);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rspValid_q <= 1'b0;
			rspData_q <= 8'h00;
			rspBit_q <= 1'b0;
		end else begin
			rspValid_q <= accept;
			if (accept) begin
				rspData_q <= curByte;
				rspBit_q <= curBit;
			end
		end
	end

	assign reqReady = reqReady_q;
	assign rspValid = rspValid_q;
	assign rspData = rspData_q;
	assign rspBit = rspBit_q;
	assign primaryValue = primary_q;
	assign secondValue = second_q;
	assign statusWord = status_q;
	assign stackPtr = coreIf.stkTop;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence pushReq;
		accept && (reqMode == MODE_PUSH);
	endsequence
	sequence popReq;
		accept && (reqMode == MODE_POP);
	endsequence
	sequence callReq;
		accept && (reqMode == MODE_CALL);
	endsequence

	chk_push_pre_incr: assert property (
		pushReq |-> (coreIf.wrEn && coreIf.wrAddr == topValue + ONE_STEP)
		##1 (topValue == $past(topValue) + ONE_STEP))
		else $error("push did not write above the old stack top");

	chk_pop_post_decr: assert property (
		popReq |-> (coreIf.rdAddr == topValue && !coreIf.wrEn)
		##1 (rspData_q == $past(coreIf.rdData) && topValue == $past(topValue) - ONE_STEP))
		else $error("pop did not read before decrementing");

	chk_call_two_bytes: assert property (
		callReq |=> (!reqReady_q && coreIf.wrEn && coreIf.wrData == $past(reqRetAddr[15:8]))
		##1 (reqReady_q && topValue == $past(topValue, 2) + TWO_STEPS))
		else $error("call did not push both return bytes");

	chk_bank_map_reg: assert property (
		accept && reqMode == MODE_WREG |->
		coreIf.rdAddr == {3'b000, status_q[BANK_SEL_LSB +: 2], reqRegNum})
		else $error("working register not in active bank");

	chk_indirect_ptr_use: assert property (
		accept && reqMode == MODE_INDIRECT && !reqWrite |->
		coreIf.ptrAddr[7:3] == {3'b000, status_q[BANK_SEL_LSB +: 2]}
		##1 rspData_q == $past(coreIf.rdData))
		else $error("indirect read not through active-bank pointer");

	chk_bit_ram_window: assert property (
		accept && bitOp && !reqAddr[7] |->
		coreIf.rdAddr == {BIT_RAM_HI, reqAddr[6:3]} ##1 rspBit_q == $past(curBit))
		else $error("bit address outside the bit-addressable RAM window");

	chk_unimpl_ones: assert property (
		accept && reqMode == MODE_DIRECT && !reqIsBit && reqAddr[7] && !specialHit(reqAddr)
		|=> rspData_q == UNIMPL_READ)
		else $error("unimplemented special address did not read ones");

	chk_special_bit_write: assert property (
		accept && bitOp && reqWrite && {reqAddr[7:3], 3'b000} == PRIMARY_REG_ADDR
		|=> primary_q[$past(bitIdx)] == $past(reqBitVal))
		else $error("bit write to special register lost");

	chk_indirect_no_special: assert property (
		accept && reqMode == MODE_INDIRECT && reqWrite |->
		coreIf.wrEn ##1 (primary_q == $past(primary_q) && second_q == $past(second_q)))
		else $error("indirect write reached the special space");
endmodule
`default_nettype wire

// [verilog/cds_pkg.sv]
// shared constants and types for the core data-space decoder
`default_nettype none
package cds_pkg;
	// special-function addresses served by this block
	localparam logic [7:0] PRIMARY_REG_ADDR = 8'he0;
	localparam logic [7:0] SECOND_REG_ADDR = 8'hf0;
	localparam logic [7:0] STATUS_WORD_ADDR = 8'hd0;
	localparam logic [7:0] STACK_TOP_ADDR = 8'h81;
	// values after reset
	localparam logic [7:0] PRIMARY_RESET = 8'h00;
	localparam logic [7:0] SECOND_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] STACK_TOP_RESET = 8'h07;
	// field positions and fixed values
	localparam int BANK_SEL_LSB = 3;
	localparam logic [3:0] BIT_RAM_HI = 4'h2;
	localparam logic [7:0] UNIMPL_READ = 8'hff;
	localparam logic [7:0] ONE_STEP = 8'h01;
	localparam logic [7:0] TWO_STEPS = 8'h02;
	localparam int RAM_DEPTH = 256;
	// operand kinds issued by the instruction decoder
	typedef enum logic [2:0] {
		MODE_DIRECT = 3'h0,
		MODE_INDIRECT = 3'h1,
		MODE_WREG = 3'h2,
		MODE_PUSH = 3'h3,
		MODE_POP = 3'h4,
		MODE_CALL = 3'h5
	} cds_mode_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_PUSH_HI = 2'b10
	} cds_state_type;
endpackage
`default_nettype wire

// [verilog/cds_core_if.sv]
// internal carrier between decoder, scratch RAM and stack pointer
`default_nettype none
interface cds_core_if;
	logic [7:0] ptrAddr;
	logic [7:0] ptrData;
	logic [7:0] rdAddr;
	logic [7:0] rdData;
	logic wrEn;
	logic [7:0] wrAddr;
	logic [7:0] wrData;
	logic stkInc;
	logic stkDec;
	logic stkLoad;
	logic [7:0] stkLoadVal;
	logic [7:0] stkTop;
	modport ctl (output ptrAddr, rdAddr, wrEn, wrAddr, wrData, stkInc, stkDec, stkLoad,
		stkLoadVal, input ptrData, rdData, stkTop);
	modport ram (input ptrAddr, rdAddr, wrEn, wrAddr, wrData, output ptrData, rdData);
	modport stk (input stkInc, stkDec, stkLoad, stkLoadVal, output stkTop);
endinterface
`default_nettype wire

// [verilog/cds_scratch_ram.sv]
// 256-byte scratch RAM with pointer and operand read ports
`default_nettype none
module cds_scratch_ram (
	// clock
	input wire logic mclk,
	// access ports
	cds_core_if.ram bus
);
	import cds_pkg::*;
	logic [7:0] mem [0:RAM_DEPTH-1];

	// no reset: contents are undefined until software writes them
	always_ff @(posedge mclk) begin
		if (bus.wrEn) begin
			mem[bus.wrAddr] <= bus.wrData;
		end
	end

	assign bus.rdData = mem[bus.rdAddr];
	assign bus.ptrData = mem[bus.ptrAddr];
endmodule
`default_nettype wire

// [verilog/cds_stack_ptr.sv]
// stack top pointer register
`default_nettype none
module cds_stack_ptr (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// control
	cds_core_if.stk bus
);
	import cds_pkg::*;
	logic [7:0] stackTop_q;
	logic firstDone_q;

	// software load wins; push and pop never share a cycle with it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stackTop_q <= STACK_TOP_RESET;
		end else if (bus.stkLoad) begin
			stackTop_q <= bus.stkLoadVal;
		end else if (bus.stkInc) begin
			stackTop_q <= stackTop_q + ONE_STEP;
		end else if (bus.stkDec) begin
			stackTop_q <= stackTop_q - ONE_STEP;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			firstDone_q <= 1'b0;
		end else begin
			firstDone_q <= 1'b1;
		end
	end

	assign bus.stkTop = stackTop_q;

	chk_top_reset_value: assert property (
		@(posedge mclk) disable iff (!reset_n) !firstDone_q |-> stackTop_q == STACK_TOP_RESET)
		else $error("stack pointer not at reset value after reset");
endmodule
`default_nettype wire

// [test/cds_data_space_tb.sv]
// self-checking bench for the core data-space decoder
`default_nettype none
module cds_data_space_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cds_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic reqValid = 1'b0;
	cds_mode_type reqMode = MODE_DIRECT;
	logic reqWrite = 1'b0;
	logic reqIsBit = 1'b0;
	logic reqPtrSel = 1'b0;
	logic reqBitVal = 1'b0;
	logic [7:0] reqAddr = 8'h00;
	logic [7:0] reqWdata = 8'h00;
	logic [2:0] reqRegNum = 3'h0;
	logic [15:0] reqRetAddr = 16'h0000;
	logic reqReady;
	logic rspValid;
	logic rspBit;
	logic [7:0] rspData;
	logic [7:0] primaryValue;
	logic [7:0] secondValue;
	logic [7:0] statusWord;
	logic [7:0] stackPtr;
	// reference state; scratch RAM starts unknown, and the first write of each byte reads it back as X
	logic [7:0] mram [256];
	logic [7:0] mPrim = 8'h00;
	logic [7:0] mSecond = 8'h00;
	logic [7:0] mStatus = 8'h00;
	logic [7:0] mTop = 8'h07;
	logic [15:0] lfsrQ = 16'h80f2;
	int mismatches = 0;
	int checked = 0;

	cds_data_space dut (.mclk(mclk), .reset_n(reset_n), .reqValid(reqValid),
		.reqMode(reqMode), .reqWrite(reqWrite), .reqIsBit(reqIsBit), .reqAddr(reqAddr),
		.reqRegNum(reqRegNum), .reqPtrSel(reqPtrSel), .reqWdata(reqWdata),
		.reqBitVal(reqBitVal), .reqRetAddr(reqRetAddr), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .rspBit(rspBit),
		.primaryValue(primaryValue), .secondValue(secondValue), .statusWord(statusWord),
		.stackPtr(stackPtr));

	initial begin
		forever #25 mclk = ~mclk;
	end

	function automatic logic [7:0] rnd();
		lfsrQ = {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ lfsrQ[12] ^ lfsrQ[10]};
		return lfsrQ[7:0];
	endfunction

	function automatic logic [7:0] byte_rd(input logic [7:0] a);
		if (!a[7])
			return mram[a];
		case (a)
			PRIMARY_REG_ADDR: return mPrim;
			SECOND_REG_ADDR: return mSecond;
			STATUS_WORD_ADDR: return mStatus;
			STACK_TOP_ADDR: return mTop;
			default: return 8'hff;
		endcase
	endfunction

	task automatic byte_wr(input logic [7:0] a, input logic [7:0] v);
		if (!a[7])
			mram[a] = v;
		else if (a == PRIMARY_REG_ADDR)
			mPrim = v;
		else if (a == SECOND_REG_ADDR)
			mSecond = v;
		else if (a == STATUS_WORD_ADDR)
			mStatus = v;
		else if (a == STACK_TOP_ADDR)
			mTop = v;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic op(input cds_mode_type m, input logic wr, input logic isBit,
		input logic [7:0] a, input logic [2:0] rn, input logic sel, input logic [7:0] wd,
		input logic bv, input logic [15:0] ret);
		logic [7:0] ea;
		logic [7:0] tmp;
		logic [7:0] expD;
		logic [7:0] bank;
		logic expB;
		logic bitOp;
		bank = {3'h0, mStatus[4:3], 3'h0};
		bitOp = (m == MODE_DIRECT) && isBit;
		expB = 1'b0;
		expD = 8'h00;
		case (m)
			MODE_DIRECT: begin
				if (isBit) begin
					ea = a[7] ? (a & 8'hf8) : {4'h2, a[6:3]};
					tmp = byte_rd(ea);
					expB = tmp[a[2:0]];
					tmp[a[2:0]] = bv;
					if (wr)
						byte_wr(ea, tmp);
				end else begin
					expD = byte_rd(a);
					if (wr)
						byte_wr(a, wd);
				end
			end
			MODE_INDIRECT, MODE_WREG: begin
				ea = (m == MODE_WREG) ? (bank | 8'(rn)) : mram[bank | 8'(sel)];
				expD = mram[ea];
				if (wr)
					mram[ea] = wd;
			end
			MODE_PUSH: begin
				mTop = mTop + 8'h01;
				mram[mTop] = wd;
			end
			MODE_POP: begin
				expD = mram[mTop];
				mTop = mTop - 8'h01;
			end
			default: begin
				mram[8'(mTop + 8'h01)] = ret[7:0];
				mram[8'(mTop + 8'h02)] = ret[15:8];
				mTop = mTop + 8'h02;
			end
		endcase
		@(posedge mclk);
		reqValid <= 1'b1;
		reqMode <= m;
		reqWrite <= wr;
		reqIsBit <= isBit;
		reqAddr <= a;
		reqRegNum <= rn;
		reqPtrSel <= sel;
		reqWdata <= wd;
		reqBitVal <= bv;
		reqRetAddr <= ret;
		@(posedge mclk);
		reqValid <= 1'b0;
		#1;
		chk("rspValid", 8'(rspValid), 8'h01);
		if (!bitOp && m != MODE_PUSH && m != MODE_CALL)
			chk("rspData", rspData, expD);
		if (bitOp)
			chk("rspBit", 8'(rspBit), 8'(expB));
		if (m == MODE_CALL) begin
			chk("reqReady", 8'(reqReady), 8'h00);
			@(posedge mclk);
			#1;
		end
		chk("primaryValue", primaryValue, mPrim);
		chk("secondValue", secondValue, mSecond);
		chk("statusWord", statusWord, mStatus);
		chk("stackPtr", stackPtr, mTop);
	endtask

	initial begin
		#1_000_000;
		mismatches++;
		wrap_up();
	end

	initial begin
		logic [7:0] r;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		#1;
		chk("stackPtr", stackPtr, STACK_TOP_RESET);
		chk("primaryValue", primaryValue, PRIMARY_RESET);
		chk("secondValue", secondValue, SECOND_RESET);
		chk("statusWord", statusWord, STATUS_RESET);
		chk("reqReady", 8'(reqReady), 8'h01);
		for (int i = 0; i < 128; i++)
			op(MODE_DIRECT, 1'b1, 1'b0, 8'(i), 3'h0, 1'b0, rnd(), 1'b0, 16'h0000);
		// upper RAM is reached only through a pointer; this loop uses the bank-0 pointer
		for (int i = 128; i < 256; i++) begin
			op(MODE_DIRECT, 1'b1, 1'b0, 8'h00, 3'h0, 1'b0, 8'(i), 1'b0, 16'h0000);
			op(MODE_INDIRECT, 1'b1, 1'b0, 8'h00, 3'h0, 1'b0, rnd(), 1'b0, 16'h0000);
		end
		for (int i = 128; i < 256; i++)
			op(MODE_DIRECT, 1'b0, 1'b0, 8'(i), 3'h0, 1'b0, 8'h00, 1'b0, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			op(MODE_DIRECT, 1'b1, 1'b0, STATUS_WORD_ADDR, 3'h0, 1'b0, 8'(k << 3), 1'b0, 16'h0000);
			for (int n = 0; n < 8; n++) begin
				op(MODE_WREG, 1'b1, 1'b0, 8'h00, 3'(n), 1'b0, rnd(), 1'b0, 16'h0000);
				op(MODE_WREG, 1'b0, 1'b0, 8'h00, 3'(n), 1'b0, 8'h00, 1'b0, 16'h0000);
			end
			for (int s = 0; s < 2; s++) begin
				op(MODE_INDIRECT, 1'b1, 1'b1, 8'hd0, 3'h0, 1'(s), rnd(), 1'b0, 16'h0000);
				op(MODE_INDIRECT, 1'b0, 1'b0, 8'h00, 3'h0, 1'(s), 8'h00, 1'b0, 16'h0000);
			end
		end
		for (int i = 0; i < 256; i++) begin
			r = rnd();
			op(MODE_DIRECT, 1'b1, 1'b1, 8'(i), 3'h0, 1'b0, 8'h00, r[0], 16'h0000);
			op(MODE_DIRECT, 1'b0, 1'b1, 8'(i), 3'h0, 1'b0, 8'h00, 1'b0, 16'h0000);
			op(MODE_DIRECT, 1'b0, 1'b0, {4'h2, 4'(i >> 3)}, 3'h0, 1'b0, 8'h00, 1'b0, 16'h0000);
		end
		// stack wraps past the top of RAM on purpose
		op(MODE_DIRECT, 1'b1, 1'b0, STACK_TOP_ADDR, 3'h0, 1'b0, 8'hfd, 1'b0, 16'h0000);
		repeat (3)
			op(MODE_PUSH, 1'b0, 1'b0, 8'h00, 3'h0, 1'b0, rnd(), 1'b0, 16'h0000);
		op(MODE_CALL, 1'b0, 1'b0, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0, {rnd(), rnd()});
		op(MODE_PUSH, 1'b0, 1'b0, 8'h00, 3'h0, 1'b0, rnd(), 1'b0, 16'h0000);
		repeat (6)
			op(MODE_POP, 1'b0, 1'b0, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0, 16'h0000);
		repeat (400) begin
			r = rnd();
			op(cds_mode_type'(3'(r % 8'h06)), r[3], r[4], rnd(), 3'(r >> 5), r[7], rnd(),
				r[6], {rnd(), rnd()});
		end
		wrap_up();
	end
endmodule
`default_nettype wire
